// ==== gfx_spi_cmd_fifo_host_test.sv ====
/*
  Self-checking bench: APB master on the host end, device end as its
  link partner, checker beside the link interface.
  Assumes zero-wait APB answers except a DATA write into a full FIFO.
*/
`timescale 1ns/1ps
`default_nettype none
module gfx_spi_cmd_fifo_host_test;
  import gsc_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        list_begin;
  logic        list_swap;
  logic [23:0] colour;
  logic [11:0] rd_ptr;
  logic [11:0] wr_ptr;
  logic [31:0] q;
  int          num_errors = 0;
  int          compares = 0;
  int          cyc = 0;
  int          nb = 0;
  int          ns = 0;

  gsc_if link ();
  gsc_host i_gsc_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  gsc_dev i_gsc_dev (.pclk(pclk), .presetn(presetn), .link(link), .list_begin(list_begin),
    .list_swap(list_swap), .colour(colour), .rd_ptr(rd_ptr), .wr_ptr(wr_ptr));
  gsc_link_checker i_gsc_link_checker (.pclk(pclk), .presetn(presetn), .cs_n(link.cs_n),
    .sck(link.sck), .mosi(link.mosi), .miso(link.miso));

  always #20 pclk = ~pclk;

  // Pulse counters and hang guard; ceiling well above a full run
  always @(posedge pclk) begin
    cyc++;
    if (list_begin === 1'b1) nb++;
    if (list_swap === 1'b1) ns++;
    if (cyc == 40000) begin
      num_errors++;
      summarize;
    end
  end

  task automatic summarize;
    if (num_errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // One frame: address, start order, then poll until idle
  task automatic frame(input logic [1:0] pfx, input logic [21:0] a, input logic [7:0] ctl);
    apb(1'b1, GSC_APB_ADDR, {8'h00, pfx, a});
    apb(1'b1, GSC_APB_CTRL, {24'h00_0000, ctl});
    do apb(1'b0, GSC_APB_STATUS, 32'h0000_0000); while (q[0] !== 1'b0);
  endtask

  task automatic put(input logic [11:0] off, input logic [31:0] w);
    apb(1'b1, GSC_APB_DATA, w);
    frame(GSC_PFX_WRITE, GSC_CMD_RAM + {10'h000, off}, 8'h01);
  endtask

  task automatic publish(input logic [11:0] wp);
    apb(1'b1, GSC_APB_DATA, {20'h0_0000, wp});
    frame(GSC_PFX_WRITE, GSC_REG_WRPTR, 8'h01);
  endtask

  // Bounded wait: garbage-free run needs at most one cycle per byte
  task automatic wait_rd(input logic [11:0] exp);
    int n = 0;
    while (rd_ptr !== exp && n < 8000) begin
      @(posedge pclk);
      n++;
    end
    chk({20'h0_0000, rd_ptr}, {20'h0_0000, exp});
  endtask

  task automatic t_reset;
    chk({20'h0_0000, rd_ptr}, 32'h0000_0000);
    chk({20'h0_0000, wr_ptr}, 32'h0000_0000);
    chk({31'h0000_0000, link.cs_n}, 32'h0000_0001);
    apb(1'b0, GSC_APB_LEVEL, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    chk({31'h0000_0000, pslverr}, 32'h0000_0000);
  endtask

  task automatic t_list;
    apb(1'b1, GSC_APB_DATA, GSC_CMD_LIST);
    apb(1'b1, GSC_APB_DATA, {GSC_OP_COLOUR, 24'hFF_FFFF});
    apb(1'b1, GSC_APB_DATA, GSC_CMD_SWAP);
    frame(GSC_PFX_WRITE, GSC_CMD_RAM, 8'h01);
    repeat (50) @(posedge pclk);
    chk({20'h0_0000, rd_ptr}, 32'h0000_0000);
    chk(nb, 32'h0000_0000);
    publish(12'h00C);
    chk({20'h0_0000, wr_ptr}, 32'h0000_000C);
    wait_rd(12'h00C);
    chk(nb, 32'h0000_0001);
    chk(ns, 32'h0000_0001);
    chk({8'h00, colour}, 32'h00FF_FFFF);
  endtask

  task automatic t_percmd;
    put(12'h00C, {GSC_OP_COLOUR, 24'h00_00FF});
    publish(12'h010);
    wait_rd(12'h010);
    chk({8'h00, colour}, 32'h0000_00FF);
  endtask

  // Fills the 16-word buffer, then sends it as one long frame
  task automatic t_fill;
    for (int i = 0; i < 16; i++) apb(1'b1, GSC_APB_DATA, {GSC_OP_COLOUR, 20'h0_0010, i[3:0]});
    apb(1'b0, GSC_APB_LEVEL, 32'h0000_0000);
    chk(q, 32'h0000_0010);
    frame(GSC_PFX_WRITE, GSC_CMD_RAM + 22'h00_0010, 8'h01);
    apb(1'b0, GSC_APB_LEVEL, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    publish(12'h050);
    wait_rd(12'h050);
    chk({8'h00, colour}, 32'h0000_010F);
  endtask

  task automatic t_read;
    frame(GSC_PFX_READ, GSC_CMD_RAM + 22'h00_0004, 8'h13);
    apb(1'b0, GSC_APB_RDATA, 32'h0000_0000);
    chk(q, 32'h04FF_FFFF);
    frame(GSC_PFX_READ, GSC_REG_RDPTR, 8'h13);
    apb(1'b0, GSC_APB_RDATA, 32'h0000_0000);
    chk(q, 32'h0000_0050);
  endtask

  // Last slot then slot zero; the read offset must wrap past 4095
  task automatic t_wrap;
    put(12'hFFC, GSC_CMD_LIST);
    put(12'h000, {GSC_OP_COLOUR, 24'h12_3456});
    publish(12'h004);
    wait_rd(12'h004);
    chk({8'h00, colour}, 32'h0012_3456);
    chk(nb, 32'h0000_0002);
  endtask

  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_list;
    t_percmd;
    t_fill;
    t_read;
    t_wrap;
    summarize;
  end
endmodule
`default_nettype wire

// ==== gsc_dev.sv ====
/*
  Device end: serial slave, command FIFO RAM, read/write pointer
  registers and a small command processor.
  Assumes mode-0 serial (sample on sck rise, shift on fall), sck at
  most pclk/4, and that the host keeps its side of the protocol.
*/
`timescale 1ns/1ps
`default_nettype none
module gsc_dev
  import gsc_pkg::*;
#(
  parameter logic [7:0] CHIP_ID = 8'h5A  // Arbitrary identity value
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  gsc_if.dev               link,
  output logic             list_begin,
  output logic             list_swap,
  output logic [23:0]      colour,
  output logic [11:0]      rd_ptr,
  output logic [11:0]      wr_ptr
);
  import gsc_pkg::*;
  typedef enum logic [2:0] {
    GSC_S_ADDR = 3'b001,
    GSC_S_WR   = 3'b010,
    GSC_S_RD   = 3'b100
  } gsc_sst_t;
  logic [7:0]  ram [GSC_FIFO_BYTES];
  logic [1:0]  cs_s, sck_s, mosi_s;
  logic        sck_d_reg;
  logic        rise, fall, cs_act;
  gsc_sst_t    st_reg, st_next;
  logic [2:0]  bit_reg, bit_next;
  logic [1:0]  abyte_reg, abyte_next;
  logic [7:0]  sh_reg, sh_next;
  logic [23:0] addr_reg, addr_next;
  logic [7:0]  tx_reg, tx_next;
  logic [11:0] wp_reg, wp_next, rp_reg, rp_next;
  logic        we;
  logic [7:0]  byte_in, rd_byte;
  logic [1:0]  ph_reg, ph_next;
  logic [31:0] word_reg, word_next;
  logic        lb_reg, lb_next, sw_reg, sw_next;
  logic [23:0] col_reg, col_next;
  assign rise    = sck_s[1] && !sck_d_reg;
  assign fall    = !sck_s[1] && sck_d_reg;
  assign cs_act  = !cs_s[1];
  assign byte_in = {sh_reg[6:0], mosi_s[1]};
  assign link.miso  = tx_reg[7];
  assign list_begin = lb_reg;
  assign list_swap  = sw_reg;
  assign colour     = col_reg;
  assign rd_ptr     = rp_reg;
  assign wr_ptr     = wp_reg;
  function automatic logic [7:0] rd_map(input logic [21:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a[21:12] == GSC_CMD_RAM[21:12]) begin
      v = ram[a[11:0]];
    end else if (a[21:2] == GSC_REG_RDPTR[21:2]) begin
      v = 8'((32'(rp_reg)) >> (8 * a[1:0]));
    end else if (a[21:2] == GSC_REG_WRPTR[21:2]) begin
      v = 8'((32'(wp_reg)) >> (8 * a[1:0]));
    end else if (a == GSC_REG_CHIPID) begin
      v = CHIP_ID;
    end
    return v;
  endfunction
  assign rd_byte = rd_map(addr_reg[21:0]);
  always_comb begin
    st_next    = st_reg;
    bit_next   = bit_reg;
    abyte_next = abyte_reg;
    sh_next    = sh_reg;
    addr_next  = addr_reg;
    tx_next    = tx_reg;
    wp_next    = wp_reg;
    we         = 1'b0;
    if (!cs_act) begin
      st_next    = GSC_S_ADDR;
      bit_next   = '0;
      abyte_next = '0;
    end else if (rise) begin
      sh_next  = byte_in;
      bit_next = 3'(bit_reg + 1'b1);
      if (bit_reg == 3'd7) begin
        unique case (st_reg)
          GSC_S_ADDR: begin
            addr_next  = {addr_reg[15:0], byte_in};
            abyte_next = 2'(abyte_reg + 1'b1);
            if (abyte_reg == 2'd2) begin
              if (addr_reg[15:14] == GSC_PFX_WRITE) begin
                st_next = GSC_S_WR;
              end else begin
                st_next = GSC_S_RD;
              end
            end
          end
          GSC_S_WR: begin
            we        = 1'b1;
            addr_next = addr_reg + 24'h00_0001;
            if (addr_reg[21:2] == GSC_REG_WRPTR[21:2]) begin
              if (addr_reg[1:0] == 2'd0) begin
                wp_next = {wp_reg[11:8], byte_in} & 12'hFFC;
              end else if (addr_reg[1:0] == 2'd1) begin
                wp_next = {byte_in[3:0], wp_reg[7:0]};
              end
            end
          end
          GSC_S_RD: begin
            addr_next = addr_reg + 24'h00_0001;
          end
        endcase
      end
    end else if (fall) begin
      if (st_reg == GSC_S_RD && bit_reg == 3'd0) begin
        tx_next = rd_byte;
      end else begin
        tx_next = {tx_reg[6:0], 1'b0};
      end
    end
  end
  // Command processor: one byte per cycle, whole word then decode
  always_comb begin
    rp_next   = rp_reg;
    ph_next   = ph_reg;
    word_next = word_reg;
    lb_next   = 1'b0;
    sw_next   = 1'b0;
    col_next  = col_reg;
    if (rp_reg != wp_reg || ph_reg != 2'd0) begin
      word_next = {ram[rp_reg], word_reg[31:8]};
      rp_next   = rp_reg + 12'h001;
      ph_next   = 2'(ph_reg + 1'b1);
      if (ph_reg == 2'd3) begin
        if (word_next == GSC_CMD_LIST) begin
          lb_next = 1'b1;
        end else if (word_next == GSC_CMD_SWAP) begin
          sw_next = 1'b1;
        end else if (word_next[31:24] == GSC_OP_COLOUR) begin
          col_next = word_next[23:0];
        end
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_s      <= 2'b11;
      sck_s     <= '0;
      mosi_s    <= '0;
      sck_d_reg <= 1'b0;
      st_reg    <= GSC_S_ADDR;
      bit_reg   <= '0;
      abyte_reg <= '0;
      sh_reg    <= '0;
      addr_reg  <= '0;
      tx_reg    <= '0;
      wp_reg    <= '0;
      rp_reg    <= '0;
      ph_reg    <= '0;
      word_reg  <= '0;
      lb_reg    <= 1'b0;
      sw_reg    <= 1'b0;
      col_reg   <= '0;
    end else begin
      cs_s      <= {cs_s[0], link.cs_n};
      sck_s     <= {sck_s[0], link.sck};
      mosi_s    <= {mosi_s[0], link.mosi};
      sck_d_reg <= sck_s[1];
      st_reg    <= st_next;
      bit_reg   <= bit_next;
      abyte_reg <= abyte_next;
      sh_reg    <= sh_next;
      addr_reg  <= addr_next;
      tx_reg    <= tx_next;
      wp_reg    <= wp_next;
      rp_reg    <= rp_next;
      ph_reg    <= ph_next;
      word_reg  <= word_next;
      lb_reg    <= lb_next;
      sw_reg    <= sw_next;
      col_reg   <= col_next;
    end
  end
  always_ff @(posedge pclk) begin
    if (we && addr_reg[21:12] == GSC_CMD_RAM[21:12]) begin
      ram[addr_reg[11:0]] <= byte_in;
    end
  end
endmodule
`default_nettype wire

// ==== gsc_fifo.sv ====
/*
  Synchronous FIFO with valid/ready on both sides.
  Assumes a single clock and active-low asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module gsc_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
  logic [AW:0]      cnt_reg, cnt_next;
  logic             push, pop;
  assign in_ready  = (cnt_reg != DEPTH[AW:0]);
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem[rd_reg];
  assign level     = cnt_reg;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  always_comb begin
    wr_next  = push ? AW'(wr_reg + 1'b1) : wr_reg;
    rd_next  = pop ? AW'(rd_reg + 1'b1) : rd_reg;
    cnt_next = cnt_reg;
    if (push && !pop) begin
      cnt_next = (AW+1)'(cnt_reg + 1'b1);
    end else if (pop && !push) begin
      cnt_next = (AW+1)'(cnt_reg - 1'b1);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end
  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wr_reg] <= in_data;
    end
  end
endmodule
`default_nettype wire

// ==== gsc_host.sv ====
/*
  Host end: APB slave with a data FIFO; runs one serial frame per
  start order: address, then FIFO words low byte first (each byte MSB first), or a read.
  Assumes an APB master that waits on pready; DATA writes stall while
  the FIFO is full.
*/
`timescale 1ns/1ps
`default_nettype none
module gsc_host
  import gsc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  gsc_if.host              link
);
  import gsc_pkg::*;
  typedef enum logic [2:0] {
    GSC_H_IDLE = 3'b001,
    GSC_H_SHIFT = 3'b010,
    GSC_H_END  = 3'b100
  } gsc_hst_t;
  gsc_hst_t    st_reg, st_next;
  logic [23:0] addr_reg, addr_next;
  logic        rd_reg, rd_next;
  logic [2:0]  nrd_reg, nrd_next;
  logic [31:0] rdat_reg, rdat_next;
  logic [31:0] sh_reg, sh_next;
  logic [5:0]  nbits_reg, nbits_next;
  logic [1:0]  phase_reg, phase_next;
  logic        cs_reg, cs_next, sck_reg, sck_next;
  logic [1:0]  div_reg;
  logic        tick, wr_acc, pop, hv;
  logic [31:0] hd;
  logic [4:0]  lvl;
  logic        in_rdy;
  gsc_fifo #(.WIDTH(32), .DEPTH(16)) u_fifo (
    .pclk(pclk), .presetn(presetn), .in_data(pwdata),
    .in_valid(wr_acc && paddr == GSC_APB_DATA), .in_ready(in_rdy),
    .out_data(hd), .out_valid(hv), .out_ready(pop), .level(lvl));
  assign wr_acc  = psel && penable && pwrite;
  assign pready  = !(wr_acc && paddr == GSC_APB_DATA && !in_rdy);
  assign pslverr = 1'b0;
  assign tick    = (div_reg == 2'(GSC_SCK_DIV - 1));
  assign link.cs_n = cs_reg;
  assign link.sck  = sck_reg;
  assign link.mosi = sh_reg[31];
  always_comb begin
    unique case (paddr)
      GSC_APB_STATUS: prdata = {31'h0000_0000, st_reg != GSC_H_IDLE};
      GSC_APB_ADDR:   prdata = {8'h00, addr_reg};
      GSC_APB_RDATA:  prdata = rdat_reg;
      GSC_APB_LEVEL:  prdata = {27'h000_0000, lvl};
      default:        prdata = 32'h0000_0000;
    endcase
  end
  always_comb begin
    st_next = st_reg; addr_next = addr_reg; rd_next = rd_reg;
    nrd_next = nrd_reg; rdat_next = rdat_reg; sh_next = sh_reg;
    nbits_next = nbits_reg; phase_next = phase_reg;
    cs_next = cs_reg; sck_next = sck_reg; pop = 1'b0;
    if (wr_acc && paddr == GSC_APB_ADDR && st_reg == GSC_H_IDLE) begin
      addr_next = pwdata[23:0];
    end
    unique case (st_reg)
      GSC_H_IDLE: begin
        if (wr_acc && paddr == GSC_APB_CTRL && pwdata[0]) begin
          rd_next    = pwdata[1];
          nrd_next   = pwdata[4:2];
          cs_next    = 1'b0;
          sh_next    = {pwdata[1] ? GSC_PFX_READ : GSC_PFX_WRITE,
                        addr_reg[21:0], 8'h00};
          nbits_next = 6'd24;
          phase_next = 2'd0;
          st_next    = GSC_H_SHIFT;
        end
      end
      GSC_H_SHIFT: begin
        if (tick) begin
          sck_next = !sck_reg;
          if (sck_reg) begin
            nbits_next = 6'(nbits_reg - 1'b1);
            sh_next    = {sh_reg[30:0], 1'b0};
            // Sample late: the device answers three pclk after a fall
            if (rd_reg && phase_reg == 2'd1) begin
              rdat_next = {rdat_reg[31:8], rdat_reg[6:0], link.miso};
              if (nbits_reg[2:0] == 3'd1) begin
                rdat_next = {rdat_reg[6:0], link.miso, rdat_reg[31:8]};
              end
            end
            if (nbits_reg == 6'd1) begin
              if (!rd_reg && hv) begin
                pop        = 1'b1;
                sh_next    = {hd[7:0], hd[15:8], hd[23:16], hd[31:24]};
                nbits_next = 6'd32;
                phase_next = 2'd1;
              end else if (rd_reg && phase_reg == 2'd0) begin
                sh_next    = 32'h0000_0000;
                nbits_next = 6'(8 * {3'b000, nrd_next});
                phase_next = 2'd1;
                if (nrd_reg == 3'd0) begin
                  st_next = GSC_H_END;
                end
              end else begin
                st_next = GSC_H_END;
              end
            end
          end
        end
      end
      GSC_H_END: begin
        if (tick) begin
          cs_next = 1'b1;
          st_next = GSC_H_IDLE;
          if (rd_reg) begin
            rdat_next = rdat_reg;
          end
        end
      end
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= GSC_H_IDLE; addr_reg <= '0; rd_reg <= 1'b0;
      nrd_reg <= '0; rdat_reg <= '0; sh_reg <= '0;
      nbits_reg <= '0; phase_reg <= '0;
      cs_reg <= 1'b1; sck_reg <= 1'b0; div_reg <= '0;
    end else begin
      st_reg <= st_next; addr_reg <= addr_next; rd_reg <= rd_next;
      nrd_reg <= nrd_next; rdat_reg <= rdat_next; sh_reg <= sh_next;
      nbits_reg <= nbits_next; phase_reg <= phase_next;
      cs_reg <= cs_next; sck_reg <= sck_next;
      // Held at zero when idle so the first sck rise gets a full half period
      div_reg <= (tick || st_reg == GSC_H_IDLE) ? 2'd0 : 2'(div_reg + 1'b1);
    end
  end
endmodule
`default_nettype wire

// ==== gsc_if.sv ====
/*
  Serial link between host and device ends.
  Assumes one pclk domain; the device synchronises its inputs.
*/
`timescale 1ns/1ps
`default_nettype none
interface gsc_if;
  logic cs_n;
  logic sck;
  logic mosi;
  logic miso;
  modport host (output cs_n, output sck, output mosi, input miso);
  modport dev  (input cs_n, input sck, input mosi, output miso);
endinterface
`default_nettype wire

// ==== gsc_link_checker.sv ====
/*
  Checker on the serial link signals between host and device ends.
  Assumes one pclk domain and the link signals as plain inputs.
*/
`timescale 1ns/1ps
`default_nettype none
module gsc_link_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic miso
);
  logic [15:0] bits_reg;
  logic [15:0] bits_next;
  logic        sck_reg;
  logic        sck_next;

  // Counts sck rises inside a frame; cleared while deselected
  always_comb begin
    bits_next = bits_reg;
    sck_next  = sck;
    if (cs_n) begin
      bits_next = 16'h0000;
    end else if (sck && !sck_reg) begin
      bits_next = bits_reg + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bits_reg <= 16'h0000;
      sck_reg  <= 1'b0;
    end else begin
      bits_reg <= bits_next;
      sck_reg  <= sck_next;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sck_idle_a: assert property (cs_n |-> !sck)
    else $error("sck moved while deselected");
  frame_open_a: assert property ($fell(cs_n) |-> !sck && bits_reg == 16'h0000)
    else $error("frame opened badly");
  frame_len_a: assert property ($rose(cs_n) |-> bits_reg >= 16'h0018 && bits_reg[2:0] == 3'h0)
    else $error("frame not address plus whole bytes");
  sck_high_a: assert property ($rose(sck) |-> ##1 sck ##1 !sck)
    else $error("sck high phase not two cycles");
  sck_low_a: assert property ($fell(sck) |-> !sck ##1 !sck)
    else $error("sck low phase too short");
  mosi_hold_a: assert property (sck && $past(sck) |-> $stable(mosi))
    else $error("mosi moved while sck high");
  mosi_setup_a: assert property ($rose(sck) |-> $stable(mosi))
    else $error("mosi moved at sampling edge");
  prefix_low_a: assert property ($rose(sck) && bits_reg == 16'h0001 |-> !mosi)
    else $error("second prefix bit not zero");
endmodule
`default_nettype wire

// ==== gsc_pkg.sv ====
/*
  Shared constants for the serial command-FIFO link: frame prefixes,
  address map of the device side, command words and FIFO geometry.
  Assumes both ends and the bench import it.
*/
`default_nettype none
package gsc_pkg;
  localparam int          GSC_ADDR_W      = 24;
  localparam logic [1:0]  GSC_PFX_WRITE   = 2'b10;
  localparam logic [1:0]  GSC_PFX_READ    = 2'b00;
  localparam int          GSC_FIFO_BYTES  = 4096;
  localparam int          GSC_OFF_W       = 12;
  localparam int          GSC_CMD_BYTES   = 4;
  localparam logic [21:0] GSC_CMD_RAM     = 22'h10_8000;
  localparam logic [21:0] GSC_REG_RDPTR   = 22'h10_20F8;
  localparam logic [21:0] GSC_REG_WRPTR   = 22'h10_20FC;
  localparam logic [21:0] GSC_REG_CHIPID  = 22'h10_2400;
  localparam logic [31:0] GSC_CMD_LIST    = 32'hFFFF_FF00;
  localparam logic [31:0] GSC_CMD_SWAP    = 32'hFFFF_FF01;
  localparam logic [7:0]  GSC_OP_COLOUR   = 8'h04;
  localparam int          GSC_SCK_DIV     = 2;
  // Host register offsets on APB
  localparam logic [7:0]  GSC_APB_CTRL    = 8'h00;
  localparam logic [7:0]  GSC_APB_STATUS  = 8'h04;
  localparam logic [7:0]  GSC_APB_DATA    = 8'h08;
  localparam logic [7:0]  GSC_APB_ADDR    = 8'h0C;
  localparam logic [7:0]  GSC_APB_RDATA   = 8'h10;
  localparam logic [7:0]  GSC_APB_LEVEL   = 8'h14;
endpackage
`default_nettype wire
